//--- src/urx_defines.svh
// constants for the oversampling serial receive front end
// assumes: included by the package and by every design file that decodes phases
// Functional notes
// - sample line sixteen times per bit
// - hunt for start after enable, stop bit
// - start qualifies: low after three highs
// - phase held at 1 while hunting
// - after qualify, phase counts bit position
// - verify at 3,5,7; two highs reject
// - bit value is majority of 8,9,10
// - any disagreeing sample sets working noise
// - start bit always taken as zero
// - character moves to buffer, full flag set
// - noise flag appears with full flag
// - phase wraps 16 to 1 each bit
// - realign phase on verified falling edge
// - framing error injects highs at 14-16
// - all-zero framing error is break, no injection
// - overrun drops new character, keeps old
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH

// ****************************************************************
// oversample phases, numbered 1..16 within a bit time
// ****************************************************************
`define URX_PH_FIRST 5'h01
`define URX_PH_SECOND 5'h02
`define URX_PH_V3 5'h03
`define URX_PH_V5 5'h05
`define URX_PH_V7 5'h07
`define URX_PH_D8 5'h08
`define URX_PH_D9 5'h09
`define URX_PH_D10 5'h0a
`define URX_PH_INJ 5'h0e
`define URX_PH_LAST 5'h10
`define URX_EP_IDLE 5'h00

// ****************************************************************
// patterns, counts and bit positions
// ****************************************************************
`define URX_HIGH3 3'h7
`define URX_VOTE_ONE 2'h1
`define URX_VOTE_MAJ 2'h2
`define URX_BIT_START 4'h0
`define URX_BIT_STEP 4'h1
`define URX_NDATA8 4'h8
`define URX_NDATA9 4'h9
`define URX_DATA_W 9
`define URX_ENTRY_W 12

`endif

//--- src/urx_pkg.sv
// types and helpers used by the receive front end: state, buffered entry, sample count and majority vote
// assumes: urx_defines.svh on the include path
`include "urx_defines.svh"

package urx_pkg;

  typedef enum logic [1:0] {
    URX_HUNT,
    URX_FRAME,
    URX_STOPW
  } urx_state_t;

  typedef struct packed {
    logic brk;
    logic bad_stop;
    logic noisy;
    logic [`URX_DATA_W-1:0] data;
  } urx_entry_t;

  function automatic logic [1:0] urx_ones3(input logic [2:0] s);
    return {1'b0, s[0]} + {1'b0, s[1]} + {1'b0, s[2]};
  endfunction : urx_ones3

  function automatic logic urx_maj3(input logic [2:0] s);
    return urx_ones3(s) >= `URX_VOTE_MAJ;
  endfunction : urx_maj3

endpackage : urx_pkg

//--- src/urx_rx_buf.sv
// small receive buffer: DEPTH words, valid/ready on both sides
// assumes: clk_sys domain, async active-low reset
`timescale 1ns/100ps

module urx_rx_buf #(
  parameter int W = 12,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  urx_stream_if.cons wr,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } urx_buf_st_t;

  urx_buf_st_t q;
  urx_buf_st_t d;
  logic do_wr;
  logic do_rd;

  function automatic logic [PW-1:0] urx_nxt(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : urx_nxt

  // full refuses the write; the producer turns that into an overrun
  assign wr.ready = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = out_valid && out_ready;

  always_comb begin
    d = q;
    if (do_wr) begin
      d.mem[q.wp] = wr.data;
      d.wp = urx_nxt(q.wp);
    end
    if (do_rd) begin
      d.rp = urx_nxt(q.rp);
    end
    d.cnt = q.cnt + CW'(do_wr) - CW'(do_rd);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : urx_rx_buf

//--- src/urx_rx_front.sv
// serial receive front end: start search, majority sampling, resync,
// framing recovery, and a small buffer for completed characters
// assumes: sample_tick is a one-cycle pulse at sixteen times the baud
// rate from an outside divider; rx_serial is already synchronous
`timescale 1ns/100ps
`include "urx_defines.svh"

module urx_rx_front
  import urx_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rx_enable,
  input wire logic nine_bit_mode,
  input wire logic sample_tick,
  input wire logic rx_serial,
  input wire logic rx_read,
  output logic receive_full_flag,
  output logic [`URX_DATA_W-1:0] receive_data_buffer,
  output logic noise_flag,
  output logic framing_error_flag,
  output logic break_flag,
  output logic overrun_pulse,
  output logic rx_busy
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    urx_state_t st;
    logic [4:0] ph;
    logic [3:0] bit_idx;
    logic [2:0] hist;
    logic [1:0] vs;
    logic [1:0] ds;
    logic voted;
    logic noise;
    logic [`URX_DATA_W-1:0] shreg;
    logic [4:0] ep;
    logic [1:0] evs;
    logic ovr;
  } urx_front_st_t;

  urx_front_st_t q;
  urx_front_st_t d;

  logic en_tick;
  logic [2:0] smp3;
  logic [2:0] edge3;
  logic [3:0] ndata;
  logic push_valid;
  logic push_ready;
  urx_entry_t push_entry;
  urx_entry_t head;
  logic bitv;
  logic noise_now;
  logic [`URX_DATA_W-1:0] char_data;
  logic realign;

  urx_stream_if #(.W(`URX_ENTRY_W)) push_if ();

  assign en_tick = rx_enable && sample_tick;
  assign smp3 = {q.ds, rx_serial};
  assign edge3 = {q.evs, rx_serial};
  assign ndata = nine_bit_mode ? `URX_NDATA9 : `URX_NDATA8;
  assign bitv = urx_maj3(smp3);
  assign char_data = nine_bit_mode ? q.shreg : {1'b0, q.shreg[`URX_DATA_W-1:1]};
  assign realign = (q.ep == `URX_PH_V7) && (urx_ones3(edge3) <= `URX_VOTE_ONE)
                   && !q.voted && (q.ph < `URX_PH_D10);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.ovr = 1'b0;
    push_valid = 1'b0;
    push_entry = '0;
    noise_now = 1'b0;
    if (!rx_enable) begin
      // history cleared so a fresh enable needs three real highs
      d = '0;
      d.st = URX_HUNT;
      d.ph = `URX_PH_FIRST;
    end else if (sample_tick) begin
      d.hist = {q.hist[1:0], rx_serial};
      case (q.st)
        URX_HUNT: begin
          d.ph = `URX_PH_FIRST;
          if (q.hist == `URX_HIGH3 && !rx_serial) begin
            d.st = URX_FRAME;
            d.ph = `URX_PH_SECOND;
            d.bit_idx = `URX_BIT_START;
            d.noise = 1'b0;
            d.voted = 1'b0;
            d.vs = '0;
            d.ds = '0;
            d.ep = `URX_EP_IDLE;
          end
        end
        URX_FRAME: begin
          d.ph = q.ph + `URX_PH_FIRST;
          // start verification, start bit only
          if (q.bit_idx == `URX_BIT_START) begin
            if (q.ph == `URX_PH_V3) begin
              d.vs[0] = rx_serial;
            end
            if (q.ph == `URX_PH_V5) begin
              d.vs[1] = rx_serial;
            end
            if (q.ph == `URX_PH_V7) begin
              if (urx_ones3({q.vs, rx_serial}) >= `URX_VOTE_MAJ) begin
                d.st = URX_HUNT;
                d.ph = `URX_PH_FIRST;
              end else if (urx_ones3({q.vs, rx_serial}) == `URX_VOTE_ONE) begin
                d.noise = 1'b1;
              end
            end
          end
          // data samples in every bit time
          if (q.ph == `URX_PH_D8) begin
            d.ds[1] = rx_serial;
          end
          if (q.ph == `URX_PH_D9) begin
            d.ds[0] = rx_serial;
          end
          if (q.ph == `URX_PH_D10) begin
            noise_now = (smp3 != '0) && (smp3 != `URX_HIGH3);
            d.voted = 1'b1;
            if (q.bit_idx == `URX_BIT_START) begin
              // start forced to zero; a high vote only counts as noise
              noise_now = noise_now || bitv;
            end else if (q.bit_idx <= ndata) begin
              d.shreg = {bitv, q.shreg[`URX_DATA_W-1:1]};
            end
            d.noise = q.noise || noise_now;
            if (q.bit_idx == ndata + `URX_BIT_STEP) begin
              push_valid = 1'b1;
              push_entry.data = char_data;
              push_entry.noisy = q.noise || noise_now;
              push_entry.bad_stop = !bitv;
              push_entry.brk = !bitv && (char_data == '0);
              d.ovr = !push_ready;
              if (push_entry.bad_stop && !push_entry.brk) begin
                d.st = URX_STOPW;
              end else begin
                d.st = URX_HUNT;
                d.ph = `URX_PH_FIRST;
              end
            end
          end
          if (q.ph == `URX_PH_LAST) begin
            d.ph = `URX_PH_FIRST;
            d.bit_idx = q.bit_idx + `URX_BIT_STEP;
            d.voted = 1'b0;
          end
          // falling-edge tracker inside the frame, data bits onward
          if (q.ep == `URX_EP_IDLE) begin
            if (q.bit_idx != `URX_BIT_START && q.hist == `URX_HIGH3 && !rx_serial) begin
              d.ep = `URX_PH_SECOND;
              d.evs = '0;
            end
          end else begin
            d.ep = q.ep + `URX_PH_FIRST;
            if (q.ep == `URX_PH_V3) begin
              d.evs[1] = rx_serial;
            end
            if (q.ep == `URX_PH_V5) begin
              d.evs[0] = rx_serial;
            end
            if (q.ep == `URX_PH_V7) begin
              d.ep = `URX_EP_IDLE;
              // only before the vote, so no bit is shifted twice
              if (realign && d.st == URX_FRAME) begin
                d.ph = `URX_PH_D8;
                d.ds = '0;
              end
            end
          end
        end
        URX_STOPW: begin
          d.ph = q.ph + `URX_PH_FIRST;
          if (q.ph >= `URX_PH_INJ) begin
            d.hist = {q.hist[1:0], 1'b1};
          end
          if (q.ph == `URX_PH_LAST) begin
            d.st = URX_HUNT;
            d.ph = `URX_PH_FIRST;
          end
        end
        default: begin
          d.st = URX_HUNT;
          d.ph = `URX_PH_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.ph <= `URX_PH_FIRST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // receive buffer
  // ****************************************************************
  // a full buffer refuses the push; the character is dropped, not stalled,
  // because the serial line cannot be held back
  assign push_if.valid = push_valid;
  assign push_if.data = push_entry;
  assign push_ready = push_if.ready;

  urx_rx_buf #(
    .W(`URX_ENTRY_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr(push_if),
    .out_valid(receive_full_flag),
    .out_data(head),
    .out_ready(rx_read)
  );

  assign receive_data_buffer = head.data;
  assign noise_flag = receive_full_flag && head.noisy;
  assign framing_error_flag = receive_full_flag && head.bad_stop;
  assign break_flag = receive_full_flag && head.brk;
  assign overrun_pulse = q.ovr;
  assign rx_busy = (q.st != URX_HUNT);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  hunt_phase_a: assert property (
    (q.st == URX_HUNT && en_tick && !(q.hist == `URX_HIGH3 && !rx_serial))
    |=> (q.st == URX_HUNT && q.ph == `URX_PH_FIRST))
    else $error("phase left 1 while hunting");

  qualify_start_a: assert property (
    (q.st == URX_HUNT && en_tick && q.hist == `URX_HIGH3 && !rx_serial)
    |=> (q.st == URX_FRAME && q.ph == `URX_PH_SECOND && q.bit_idx == `URX_BIT_START))
    else $error("qualified start not taken");

  verify_drop_a: assert property (
    (q.st == URX_FRAME && en_tick && q.bit_idx == `URX_BIT_START
     && q.ph == `URX_PH_V7 && urx_ones3({q.vs, rx_serial}) >= `URX_VOTE_MAJ)
    |=> (q.st == URX_HUNT && q.ph == `URX_PH_FIRST))
    else $error("false start not rejected");

  verify_noise_a: assert property (
    (q.st == URX_FRAME && en_tick && q.bit_idx == `URX_BIT_START
     && q.ph == `URX_PH_V7 && urx_ones3({q.vs, rx_serial}) == `URX_VOTE_ONE)
    |=> (q.noise && q.st == URX_FRAME))
    else $error("single high verify sample not noted");

  phase_wrap_a: assert property (
    (q.st == URX_FRAME && en_tick && q.ph == `URX_PH_LAST)
    |=> (q.ph == `URX_PH_FIRST && q.bit_idx == $past(q.bit_idx) + `URX_BIT_STEP))
    else $error("phase did not wrap at bit end");

  bit_vote_a: assert property (
    (q.st == URX_FRAME && en_tick && q.ph == `URX_PH_D10
     && q.bit_idx != `URX_BIT_START && q.bit_idx <= ndata)
    |=> (q.shreg[`URX_DATA_W-1] == urx_maj3($past(smp3))))
    else $error("bit value is not the majority");

  edge_align_a: assert property (
    (q.st == URX_FRAME && en_tick && realign && q.bit_idx <= ndata)
    |=> (q.ph == `URX_PH_D8 && q.ep == `URX_EP_IDLE))
    else $error("phase not realigned on edge");

  push_full_a: assert property (
    (push_valid && push_ready && !receive_full_flag)
    |=> (receive_full_flag && receive_data_buffer == $past(push_entry.data)))
    else $error("character not moved to buffer");

  noise_same_a: assert property (
    (push_valid && push_ready && !receive_full_flag)
    |=> (noise_flag == $past(push_entry.noisy)
         && framing_error_flag == $past(push_entry.bad_stop)))
    else $error("noise flag not with full flag");

  inject_high_a: assert property (
    (q.st == URX_STOPW && en_tick && q.ph == `URX_PH_LAST)
    |=> (q.hist == `URX_HIGH3 && q.st == URX_HUNT))
    else $error("highs not injected after framing error");

  stop_wait_a: assert property (
    (push_valid && push_entry.bad_stop && !push_entry.brk)
    |=> (q.st == URX_STOPW))
    else $error("framing error skipped the stop wait");

  break_skip_a: assert property (
    (push_valid && push_entry.brk) |=> (q.st == URX_HUNT && q.ph == `URX_PH_FIRST))
    else $error("break took the injection path");

  overrun_keep_a: assert property (
    (push_valid && !push_ready && !rx_read)
    |=> ($stable(receive_data_buffer) && receive_full_flag && overrun_pulse))
    else $error("overrun disturbed buffered character");

endmodule : urx_rx_front

//--- src/urx_stream_if.sv
// valid/ready word channel between the front end and its buffer
// assumes: one clock, data stable while valid waits for ready
`timescale 1ns/100ps

interface urx_stream_if #(
  parameter int W = 12
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport prod (
    output valid,
    output data,
    input ready
  );

  modport cons (
    input valid,
    input data,
    output ready
  );
endinterface : urx_stream_if

//--- tb/urx_rx_front_tb.sv
// self-checking bench for the oversampling receive front end
// assumes: design sources and the sender model compiled first
`timescale 1ns/100ps
`include "urx_defines.svh"

module urx_rx_front_tb;
  logic clk_sys, resetn, rx_enable, nine_bit_mode, sample_tick, rx_serial, rx_read;
  logic receive_full_flag, noise_flag, framing_error_flag, break_flag;
  logic overrun_pulse, rx_busy;
  logic [`URX_DATA_W-1:0] receive_data_buffer;
  logic [11:0] head;
  logic [1:0] tick_div;
  int err_total, cmp_count, cyc, ovr_seen;

  assign head = {break_flag, framing_error_flag, noise_flag, receive_data_buffer};

  urx_rx_front #(.BUF_DEPTH(2)) DUT (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rx_enable(rx_enable),
    .nine_bit_mode(nine_bit_mode),
    .sample_tick(sample_tick),
    .rx_serial(rx_serial),
    .rx_read(rx_read),
    .receive_full_flag(receive_full_flag),
    .receive_data_buffer(receive_data_buffer),
    .noise_flag(noise_flag),
    .framing_error_flag(framing_error_flag),
    .break_flag(break_flag),
    .overrun_pulse(overrun_pulse),
    .rx_busy(rx_busy)
  );

  urx_tx_model tx_model (
    .clk_sys(clk_sys),
    .sample_tick(sample_tick),
    .tx_line(rx_serial)
  );

  // ****************************************************************
  // clock, sample tick, overrun count, timeout
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // tick every fourth clock keeps frames short
  always @(posedge clk_sys) begin
    tick_div <= tick_div + 2'h1;
    sample_tick <= (tick_div == 2'h3);
    cyc <= cyc + 1;
    if (overrun_pulse === 1'b1) ovr_seen <= ovr_seen + 1;
    if (cyc == 30000) begin
      err_total++;
      end_sim();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tx(input logic [8:0] d, input logic nine, input int len, input logic stop_v,
                    input int pre, input int nz, input int nlen);
    @(posedge clk_sys);
    nine_bit_mode <= nine;
    tx_model.send(d, nine, len, stop_v, pre, nz, nlen);
  endtask : tx

  // check head word, pop it, then check whether more remain
  task automatic look(input logic [11:0] exp, input logic more);
    #1;
    chk({11'h000, receive_full_flag}, 12'h001);
    chk(head, exp);
    @(posedge clk_sys);
    rx_read <= 1'b1;
    @(posedge clk_sys);
    rx_read <= 1'b0;
    #1;
    chk({11'h000, receive_full_flag}, {11'h000, more});
  endtask : look

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_basic();
    tx(9'h0a5, 1'b0, 16, 1'b1, 20, -1, 0);
    look(12'h0a5, 1'b0);
    #1;
    chk({11'h000, rx_busy}, 12'h000);
    tx(9'h1c3, 1'b1, 16, 1'b1, 8, -1, 0);
    look(12'h1c3, 1'b0);
    tx(9'h000, 1'b0, 16, 1'b1, 8, -1, 0);
    look(12'h000, 1'b0);
  endtask : t_basic

  // reader stalls: third character must be dropped
  task automatic t_overrun();
    int base;
    base = ovr_seen;
    tx(9'h011, 1'b0, 16, 1'b1, 4, -1, 0);
    tx(9'h022, 1'b0, 16, 1'b1, 4, -1, 0);
    chk(12'(ovr_seen - base), 12'h000);
    tx(9'h033, 1'b0, 16, 1'b1, 4, -1, 0);
    chk(12'(ovr_seen - base), 12'h001);
    look(12'h011, 1'b1);
    look(12'h022, 1'b0);
  endtask : t_overrun

  // bad stop, then next start with no idle at all
  task automatic t_framing();
    tx(9'h055, 1'b0, 16, 1'b0, 8, -1, 0);
    tx(9'h03c, 1'b0, 16, 1'b1, 0, -1, 0);
    look(12'h455, 1'b1);
    look(12'h03c, 1'b0);
    tx(9'h000, 1'b0, 16, 1'b0, 8, -1, 0);
    look(12'hc00, 1'b0);
    tx(9'h0e7, 1'b0, 16, 1'b1, 20, -1, 0);
    look(12'h0e7, 1'b0);
  endtask : t_framing

  // glitches in idle and within the start and data bits
  task automatic t_noise();
    tx(9'h05a, 1'b0, 16, 1'b1, 20, 5, 1);
    look(12'h05a, 1'b0);
    tx(9'h05a, 1'b0, 16, 1'b1, 8, 10, 1);
    look(12'h25a, 1'b0);
    tx(9'h05a, 1'b0, 16, 1'b1, 8, 16, 2);
    look(12'h25a, 1'b0);
    tx(9'h05a, 1'b0, 16, 1'b1, 8, 8 + 16 * 3 + 8, 1);
    look(12'h25a, 1'b0);
  endtask : t_noise

  // off-rate senders only survive through edge realignment
  task automatic t_resync();
    tx(9'h055, 1'b0, 17, 1'b1, 8, -1, 0);
    look(12'h055, 1'b0);
    tx(9'h055, 1'b0, 15, 1'b1, 8, -1, 0);
    look(12'h055, 1'b0);
  endtask : t_resync

  task automatic t_enable();
    @(posedge clk_sys);
    rx_enable <= 1'b0;
    tx(9'h077, 1'b0, 16, 1'b1, 8, -1, 0);
    #1;
    chk({11'h000, receive_full_flag}, 12'h000);
    @(posedge clk_sys);
    rx_enable <= 1'b1;
    tx(9'h066, 1'b0, 16, 1'b1, 8, -1, 0);
    look(12'h066, 1'b0);
  endtask : t_enable

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    rx_enable = 1'b1;
    nine_bit_mode = 1'b0;
    sample_tick = 1'b0;
    rx_read = 1'b0;
    tick_div = 2'h0;
    cyc = 0;
    ovr_seen = 0;
    err_total = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_basic();
    t_overrun();
    t_framing();
    t_noise();
    t_resync();
    t_enable();
    end_sim();
  end
endmodule : urx_rx_front_tb

//--- tb/urx_tx_model.sv
// remote serial sender model facing the receive front end
// assumes: sample_tick pulses once per sixteenth of a nominal bit; line idles high
`timescale 1ns/100ps

module urx_tx_model (
  input wire logic clk_sys,
  input wire logic sample_tick,
  output logic tx_line
);
  // ****************************************************************
  // frame sender
  // ****************************************************************
  initial tx_line = 1'b1;

  // bit_len off 16 gives a slow or fast sender; the nz window inverts samples
  task automatic send(input logic [8:0] data, input logic nine, input int bit_len,
                      input logic stop_v, input int pre, input int nz, input int nlen);
    logic [10:0] bits;
    logic v;
    int nb;
    int k;
    nb = nine ? 11 : 10;
    bits = nine ? {stop_v, data, 1'b0} : {1'b0, stop_v, data[7:0], 1'b0};
    for (k = 0; k < pre + nb * bit_len; k++) begin
      v = (k < pre) ? 1'b1 : bits[(k - pre) / bit_len];
      tx_line <= v ^ (k >= nz && k < nz + nlen);
      do @(posedge clk_sys); while (sample_tick !== 1'b1);
    end
    // back to idle so a low stop bit does not linger past its frame
    tx_line <= 1'b1;
  endtask : send
endmodule : urx_tx_model
